// *** common/cbss_consts.vh ***
// Constants for the CPU bank, stack and status register block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef CBSS_CONSTS_VH
`define CBSS_CONSTS_VH

// Data memory nibble addresses of the status word
`define CBSS_ADDR_PSW_LO 12'hfb0
`define CBSS_ADDR_PSW_HI 12'hfb1
// Nibble addresses chosen for stack pointer, stack bank and bank select
`define CBSS_ADDR_SP_LO 12'hf80
`define CBSS_ADDR_SP_HI 12'hf81
`define CBSS_ADDR_SBS 12'hf84
`define CBSS_ADDR_BS_LO 12'hf82
`define CBSS_ADDR_BS_HI 12'hf83

// Status word bit positions
`define CBSS_PSW_CY 7
`define CBSS_PSW_SK_HI 6
`define CBSS_PSW_SK_LO 4
`define CBSS_PSW_IST_HI 3
`define CBSS_PSW_IST_LO 2
`define CBSS_PSW_MBE 1
`define CBSS_PSW_RBE 0

// Vector byte bit positions for expand flags
`define CBSS_VEC_MBE 7
`define CBSS_VEC_RBE 6

// Nesting levels
`define CBSS_IST_NORMAL 2'h0
`define CBSS_IST_ONE 2'h1
`define CBSS_IST_TWO 2'h2
`define CBSS_IST_BAD 2'h3

// Allowed memory banks
`define CBSS_MB_0 4'h0
`define CBSS_MB_3 4'h3
`define CBSS_MB_15 4'hf

// Reset and helper values
`define CBSS_ZERO4 4'h0
`define CBSS_ZERO2 2'h0
`define CBSS_ZERO3 3'h0
`define CBSS_ZERO8 8'h00
`define CBSS_ZERO1 1'b0
`define CBSS_ONE8 8'h01
`define CBSS_PTR_INIT 8'h00

// Stack operation codes
`define CBSS_OP_NONE 3'h0
`define CBSS_OP_PUSH 3'h1
`define CBSS_OP_POP 3'h2
`define CBSS_OP_CALL 3'h3
`define CBSS_OP_RET 3'h4
`define CBSS_OP_INTA 3'h5
`define CBSS_OP_INTERRUPT_RETURN 3'h6

`endif

// *** logic/cbss_stack_addr.v ***
// Stack pointer and stack address generator.
// Assumes one clock and a sequencer that issues at most one push or pop a cycle.
`default_nettype none
`include "cbss_consts.vh"

module cbss_stack_addr (
    input wire ref_clk,
    input wire rstn,
    input wire sp_wr_en,
    input wire [7:0] sp_wr_data,
    input wire push,
    input wire pop,
    input wire [1:0] stack_bank,
    output reg [7:0] stack_top_pointer,
    output wire [9:0] push_addr,
    output wire [9:0] pop_addr
);
    reg [7:0] sp_q;
    reg [7:0] sp_d;
    wire [7:0] sp_dec;

    // Eight-bit wrap keeps the stack inside its bank
    assign sp_dec = sp_q - `CBSS_ONE8;
    assign push_addr = {stack_bank, sp_dec};
    assign pop_addr = {stack_bank, sp_q};

    // Pre-decrement on save, post-increment on restore
    always @* begin
        sp_d = sp_q;
        if (sp_wr_en) begin
            sp_d = sp_wr_data;
        end else if (push) begin
            sp_d = sp_dec;
        end else if (pop) begin
            sp_d = sp_q + `CBSS_ONE8;
        end
    end

    // Reset loads 00H; software must still load it before use
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sp_q <= `CBSS_PTR_INIT;
        end else begin
            sp_q <= sp_d;
        end
    end

    always @* begin
        stack_top_pointer = sp_q;
    end
endmodule
`default_nettype wire

// *** logic/cbss_regs.v ***
// CPU bank select, stack pointer and status word registers of a 4-bit core.
// Assumes the execution unit drives one stack op per cycle, in step with ref_clk,
// and supplies memory data for pops and vector bits for interrupt entry.
`default_nettype none
`include "cbss_consts.vh"

// Contract
// - Active register bank is expand flag ANDed with bank choice.
// - Registers usable as nibbles; BC, DE, HL, XA pairs; DL, DE, HL pointers.
// - Eight-bit stack top pointer holds the current LIFO stack address.
// - Two-bit stack bank choice picks memory bank 0 to 3.
// - Pointer decrements before each save and increments after each restore.
// - Stack bank choice written as nibble; upper two bits read zero.
// - Pointer at 00H makes next save use address nFFH.
// - Stack addressing wraps inside the selected bank.
// - Pointer and stack bank undefined after reset; software initialises them. Reset here clears both to zero.
// - Calls save only the two expand flags; returns restore only them.
// - Interrupt entry saves whole status word; interrupt return restores it.
// - Status word sits at FB0H and FB1H; FB0H nibble memory-accessible.
// - Carry holds add/subtract carry and Boolean accumulator; reset undefined. Reset here clears it.
// - Nesting codes: 0 any, 1 higher only, 2 none, 3 never.
// - Interrupt entry saves nesting level then advances it one step.
// - With memory expand set, bank choice forms upper address nibble.
// - Memory expand loads bit 7 of reset or vector entry.
// - Register expand loads bit 6 of reset or vector entry.
// - Memory bank choice accepts 0-3 and 15 only; reset clears it.
// - Register bank choice takes 0 to 3; reset clears it.
// - Bank select pair pushes and pops as one byte.
module cbss_regs (
    input wire ref_clk,
    input wire rstn,
    // Data memory manipulation access
    input wire mem_wr,
    input wire [11:0] mem_addr,
    input wire [3:0] mem_wdata,
    output reg [3:0] mem_rdata,
    output reg mem_hit,
    // Vector byte for reset and interrupt entry
    input wire boot_load,
    input wire [7:0] vector_byte,
    // Bank select instructions
    input wire sel_mb,
    input wire sel_rb,
    input wire [3:0] sel_value,
    // Carry and skip updates from the ALU
    input wire carry_wr,
    input wire carry_in,
    input wire skip_wr,
    input wire [2:0] skip_in,
    // Stack operation request
    input wire [2:0] stack_op,
    input wire [7:0] stack_pop_data,
    output reg [7:0] stack_push_data,
    output wire [9:0] stack_push_addr,
    output wire [9:0] stack_pop_addr,
    // Register file pointers
    input wire [2:0] reg_sel,
    input wire [1:0] pair_sel,
    output wire [1:0] active_register_bank,
    output wire [4:0] reg_nibble_addr,
    output wire [4:0] pair_even_addr,
    output wire [4:0] ptr_de_addr,
    output wire [4:0] ptr_hl_addr,
    output wire [4:0] ptr_dl_d_addr,
    output wire [4:0] ptr_dl_l_addr,
    // Address and status views
    input wire [7:0] data_offset,
    output wire [11:0] data_address,
    output wire [1:0] nesting_level,
    output wire carry_bit,
    output wire [7:0] stack_top_pointer,
    output wire [1:0] stack_bank
);
    // Status word fields and bank state
    reg carry_q;
    reg [2:0] skip_q;
    reg [1:0] ist_q;
    reg mbe_q;
    reg rbe_q;
    reg [3:0] mbs_q;
    reg [1:0] rbs_q;
    reg [1:0] sbs_q;
    wire [7:0] processor_flags_word;
    wire [7:0] bs_pair;
    wire push_any;
    wire pop_any;
    wire sp_wr_en;
    reg [7:0] sp_wr_data;

    // Register numbers within a bank, order B C D E H L X A
    localparam [2:0] RN_D = 3'h2;
    localparam [2:0] RN_E = 3'h3;
    localparam [2:0] RN_H = 3'h4;
    localparam [2:0] RN_L = 3'h5;

    // Nibble address of register n in the active bank
    function [4:0] reg_addr;
        input [1:0] bank;
        input [2:0] n;
        begin
            reg_addr = {bank, n};
        end
    endfunction

    // Only banks 0..3 and 15 are legal memory banks
    function mb_legal;
        input [3:0] v;
        begin
            mb_legal = (v <= `CBSS_MB_3) || (v == `CBSS_MB_15);
        end
    endfunction

    // One step up the nesting ladder; level 2 is the ceiling, 3 never made
    function [1:0] ist_next;
        input [1:0] v;
        begin
            case (v)
                `CBSS_IST_NORMAL: ist_next = `CBSS_IST_ONE;
                `CBSS_IST_ONE: ist_next = `CBSS_IST_TWO;
                default: ist_next = `CBSS_IST_TWO;
            endcase
        end
    endfunction

    assign processor_flags_word = {carry_q, skip_q, ist_q, mbe_q, rbe_q};
    assign bs_pair = {mbs_q, `CBSS_ZERO2, rbs_q};
    assign push_any = (stack_op == `CBSS_OP_PUSH) || (stack_op == `CBSS_OP_CALL) ||
        (stack_op == `CBSS_OP_INTA);
    assign pop_any = (stack_op == `CBSS_OP_POP) || (stack_op == `CBSS_OP_RET) ||
        (stack_op == `CBSS_OP_INTERRUPT_RETURN);

    // Active bank gating
    assign active_register_bank = rbs_q & {2{rbe_q}};
    assign reg_nibble_addr = reg_addr(active_register_bank, reg_sel);
    assign pair_even_addr = reg_addr(active_register_bank, {pair_sel, 1'b0});
    assign ptr_de_addr = reg_addr(active_register_bank, RN_D);
    assign ptr_hl_addr = reg_addr(active_register_bank, RN_H);
    assign ptr_dl_d_addr = reg_addr(active_register_bank, RN_D);
    assign ptr_dl_l_addr = reg_addr(active_register_bank, RN_L);

    // Fixed bank 0 when expansion off; full space via bank choice otherwise
    assign data_address = {(mbe_q ? mbs_q : `CBSS_ZERO4), data_offset};
    assign nesting_level = ist_q;
    assign carry_bit = carry_q;
    assign stack_bank = sbs_q;

    // Eight-bit pointer loads as two nibbles through memory writes
    assign sp_wr_en = mem_wr && ((mem_addr == `CBSS_ADDR_SP_LO) ||
        (mem_addr == `CBSS_ADDR_SP_HI));
    always @* begin
        sp_wr_data = stack_top_pointer;
        if (mem_addr == `CBSS_ADDR_SP_LO) begin
            sp_wr_data = {stack_top_pointer[7:4], mem_wdata};
        end else begin
            sp_wr_data = {mem_wdata, stack_top_pointer[3:0]};
        end
    end

    cbss_stack_addr u_stack (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .sp_wr_en(sp_wr_en),
        .sp_wr_data(sp_wr_data),
        .push(push_any),
        .pop(pop_any),
        .stack_bank(sbs_q),
        .stack_top_pointer(stack_top_pointer),
        .push_addr(stack_push_addr),
        .pop_addr(stack_pop_addr)
    );

    // Byte offered to the stack for each kind of save
    always @* begin
        case (stack_op)
            `CBSS_OP_PUSH: stack_push_data = bs_pair;
            `CBSS_OP_CALL: stack_push_data = {6'h00, mbe_q, rbe_q};
            `CBSS_OP_INTA: stack_push_data = processor_flags_word;
            default: stack_push_data = `CBSS_ZERO8;
        endcase
    end

    // Memory-mapped read view; pair halves and status nibbles
    always @* begin
        mem_hit = 1'b1;
        case (mem_addr)
            `CBSS_ADDR_PSW_LO: mem_rdata = processor_flags_word[3:0];
            `CBSS_ADDR_PSW_HI: mem_rdata = processor_flags_word[7:4];
            `CBSS_ADDR_SP_LO: mem_rdata = stack_top_pointer[3:0];
            `CBSS_ADDR_SP_HI: mem_rdata = stack_top_pointer[7:4];
            `CBSS_ADDR_SBS: mem_rdata = {`CBSS_ZERO2, sbs_q};
            `CBSS_ADDR_BS_LO: mem_rdata = bs_pair[3:0];
            `CBSS_ADDR_BS_HI: mem_rdata = bs_pair[7:4];
            default: begin
                mem_rdata = `CBSS_ZERO4;
                mem_hit = 1'b0;
            end
        endcase
    end

    // Stack bank: only the low two bits are held
    // Reset clears it to bank 0; software sets it first
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sbs_q <= `CBSS_ZERO2;
        end else if (mem_wr && mem_addr == `CBSS_ADDR_SBS) begin
            sbs_q <= mem_wdata[1:0];
        end
    end

    // Bank choices; illegal memory banks are refused and leave the old value
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mbs_q <= `CBSS_ZERO4;
            rbs_q <= `CBSS_ZERO2;
        end else if (stack_op == `CBSS_OP_POP) begin
            if (mb_legal(stack_pop_data[7:4])) begin
                mbs_q <= stack_pop_data[7:4];
            end
            rbs_q <= stack_pop_data[1:0];
        end else begin
            if (sel_mb && mb_legal(sel_value)) begin
                mbs_q <= sel_value;
            end
            if (sel_rb) begin
                rbs_q <= sel_value[1:0];
            end
        end
    end

    // Carry: interrupt return restores it and outranks ALU updates in the same cycle
    // Reset value arbitrary in the architecture; cleared here for determinism
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            carry_q <= `CBSS_ZERO1;
            skip_q <= `CBSS_ZERO3;
        end else if (stack_op == `CBSS_OP_INTERRUPT_RETURN) begin
            carry_q <= stack_pop_data[`CBSS_PSW_CY];
            skip_q <= stack_pop_data[`CBSS_PSW_SK_HI:`CBSS_PSW_SK_LO];
        end else begin
            if (carry_wr) begin
                carry_q <= carry_in;
            end
            if (skip_wr) begin
                skip_q <= skip_in;
            end
        end
    end

    // Nesting level and expand flags; a code of 3 written by software is
    // dropped, but interrupt return loads any code. Writers mask interrupts
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ist_q <= `CBSS_IST_NORMAL;
            mbe_q <= `CBSS_ZERO1;
            rbe_q <= `CBSS_ZERO1;
        end else if (boot_load) begin
            mbe_q <= vector_byte[`CBSS_VEC_MBE];
            rbe_q <= vector_byte[`CBSS_VEC_RBE];
        end else begin
            case (stack_op)
                `CBSS_OP_INTA: begin
                    ist_q <= ist_next(ist_q);
                    mbe_q <= vector_byte[`CBSS_VEC_MBE];
                    rbe_q <= vector_byte[`CBSS_VEC_RBE];
                end
                `CBSS_OP_INTERRUPT_RETURN: begin
                    ist_q <= stack_pop_data[`CBSS_PSW_IST_HI:`CBSS_PSW_IST_LO];
                    mbe_q <= stack_pop_data[`CBSS_PSW_MBE];
                    rbe_q <= stack_pop_data[`CBSS_PSW_RBE];
                end
                `CBSS_OP_RET: begin
                    mbe_q <= stack_pop_data[`CBSS_PSW_MBE];
                    rbe_q <= stack_pop_data[`CBSS_PSW_RBE];
                end
                default: begin
                    if (mem_wr && mem_addr == `CBSS_ADDR_PSW_LO) begin
                        if (mem_wdata[3:2] != `CBSS_IST_BAD) begin
                            ist_q <= mem_wdata[3:2];
                        end
                        mbe_q <= mem_wdata[`CBSS_PSW_MBE];
                        rbe_q <= mem_wdata[`CBSS_PSW_RBE];
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** testbench/cbss_regs_chk.sv ***
// Port-level assertions for the bank, stack and status register block.
// Assumes one clock domain and the stack op codes of the block's constants.
`default_nettype none

module cbss_regs_chk (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic mem_wr,
    input wire logic [11:0] mem_addr,
    input wire logic [3:0] mem_rdata,
    input wire logic boot_load,
    input wire logic [7:0] vector_byte,
    input wire logic [2:0] stack_op,
    input wire logic [7:0] stack_push_data,
    input wire logic [9:0] stack_push_addr,
    input wire logic [9:0] stack_pop_addr,
    input wire logic [1:0] active_register_bank,
    input wire logic [7:0] data_offset,
    input wire logic [11:0] data_address,
    input wire logic [1:0] nesting_level,
    input wire logic [7:0] stack_top_pointer,
    input wire logic [1:0] stack_bank
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // Pointer moves on every save or restore unless a write to its nibbles outranks the op
    a_bank_clear: assert property (boot_load && !vector_byte[6] |=> active_register_bank == 2'h0)
        else $error("register bank not zero with expand clear");
    a_addr_fixed: assert property (boot_load && !vector_byte[7] && !mem_wr |=>
        data_address == {4'h0, data_offset})
        else $error("data address not fixed with expand clear");
    a_push_wrap: assert property (stack_push_addr == {stack_bank, stack_top_pointer - 8'h01})
        else $error("push address not pointer minus one in bank");
    a_pop_place: assert property (stack_pop_addr == {stack_bank, stack_top_pointer})
        else $error("pop address not pointer in bank");
    a_push_dec: assert property ((stack_op == 3'h1 || stack_op == 3'h3 || stack_op == 3'h5)
        && !mem_wr && !boot_load |=> stack_top_pointer == $past(stack_top_pointer) - 8'h01)
        else $error("pointer not decremented by save");
    a_pop_inc: assert property ((stack_op == 3'h2 || stack_op == 3'h4 || stack_op == 3'h6)
        && !mem_wr && !boot_load |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
        else $error("pointer not incremented by restore");
    a_sbank_high: assert property (mem_addr == 12'hf84 |-> mem_rdata[3:2] == 2'h0)
        else $error("stack bank upper bits not zero");
    a_nest_legal: assert property (nesting_level != 2'h3)
        else $error("nesting level holds forbidden code");
    a_nest_step: assert property (stack_op == 3'h5 && nesting_level == 2'h0 && !mem_wr
        && !boot_load |=> nesting_level == 2'h1)
        else $error("nesting level not advanced on accept");
    a_call_flags: assert property (stack_op == 3'h3 |-> stack_push_data[7:2] == 6'h00)
        else $error("call saved more than expand flags");
endmodule

bind cbss_regs cbss_regs_chk cbss_regs_chk_i (.ref_clk, .rstn, .mem_wr, .mem_addr, .mem_rdata,
    .boot_load, .vector_byte, .stack_op, .stack_push_data, .stack_push_addr, .stack_pop_addr,
    .active_register_bank, .data_offset, .data_address, .nesting_level, .stack_top_pointer,
    .stack_bank);
`default_nettype wire

// *** testbench/cbss_stack_mem.sv ***
// Stack memory on the execution side: keeps saved bytes and returns them.
// Assumes one stack op a cycle on the block's codes.
`default_nettype none

module cbss_stack_mem (
    input wire logic ref_clk,
    input wire logic [2:0] stack_op,
    input wire logic [9:0] push_addr,
    input wire logic [7:0] push_data,
    input wire logic [9:0] pop_addr,
    output logic [7:0] pop_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ram [0:1023];
    logic rd_q;
    // Saves land on the edge that takes the op
    always @(posedge ref_clk) begin
        if (stack_op == 3'h1 || stack_op == 3'h3 || stack_op == 3'h5) begin
            ram[push_addr] <= push_data;
        end
    end
    // Outside a restore show the inverse so stale data never passes
    assign rd_q = stack_op == 3'h2 || stack_op == 3'h4 || stack_op == 3'h6;
    assign pop_data = rd_q ? ram[pop_addr] : ~ram[pop_addr];
endmodule
`default_nettype wire

// *** testbench/cbss_regs_tb.sv ***
// Self-checking bench for the bank, stack and status register block.
// Assumes the stack memory model answers restores in the op cycle.
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s expected %h seen %h", n, e, g); end end

module cbss_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rstn, mem_wr, mem_hit, boot_load, sel_mb, sel_rb, carry_wr, carry_in;
    logic carry_bit, skip_wr;
    logic [2:0] skip_in, reg_sel;
    logic [1:0] pair_sel;
    logic [4:0] rn_addr, pr_addr, de_addr, hl_addr, dld_addr, dll_addr;
    logic [11:0] mem_addr, data_address;
    logic [3:0] mem_wdata, mem_rdata, sel_value;
    logic [7:0] vector_byte, pop_data, push_data, data_offset, sp;
    logic [2:0] stack_op;
    logic [9:0] push_addr, pop_addr;
    logic [1:0] rbank, nest, sbank;
    int err_count = 0, cmp_count = 0;

    cbss_regs cbss_regs_i (.ref_clk(ref_clk), .rstn(rstn), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_hit(mem_hit),
        .boot_load(boot_load), .vector_byte(vector_byte), .sel_mb(sel_mb), .sel_rb(sel_rb),
        .sel_value(sel_value), .carry_wr(carry_wr), .carry_in(carry_in), .skip_wr(skip_wr),
        .skip_in(skip_in), .stack_op(stack_op), .stack_pop_data(pop_data),
        .stack_push_data(push_data), .stack_push_addr(push_addr), .stack_pop_addr(pop_addr),
        .reg_sel(reg_sel), .pair_sel(pair_sel), .active_register_bank(rbank),
        .reg_nibble_addr(rn_addr), .pair_even_addr(pr_addr), .ptr_de_addr(de_addr),
        .ptr_hl_addr(hl_addr), .ptr_dl_d_addr(dld_addr), .ptr_dl_l_addr(dll_addr),
        .data_offset(data_offset), .data_address(data_address), .nesting_level(nest),
        .carry_bit(carry_bit), .stack_top_pointer(sp), .stack_bank(sbank));
    cbss_stack_mem cbss_stack_mem_i (.ref_clk(ref_clk), .stack_op(stack_op),
        .push_addr(push_addr), .push_data(push_data), .pop_addr(pop_addr), .pop_data(pop_data));

    always #20 ref_clk = ~ref_clk;

    // Codes 0-6 are stack ops; 8 boot load, 9 memory bank, a register bank, b carry, c skip
    task automatic go(input logic [3:0] k, input logic [7:0] v);
        vector_byte = v;
        sel_value = v[3:0];
        carry_in = v[0];
        skip_in = v[2:0];
        skip_wr = k == 4'hc;
        boot_load = k == 4'h8;
        sel_mb = k == 4'h9;
        sel_rb = k == 4'ha;
        carry_wr = k == 4'hb;
        stack_op = k[3] ? 3'h0 : k[2:0];
    endtask
    // Requests stand one edge, then one idle cycle keeps drives apart
    task automatic fin();
        @(negedge ref_clk);
        go(4'hf, 8'h00);
        @(negedge ref_clk);
    endtask
    task automatic mw(input logic [11:0] a, input logic [3:0] d);
        mem_addr = a;
        mem_wdata = d;
        mem_wr = 1'b1;
        @(negedge ref_clk);
        mem_wr = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [3:0] e);
        mem_addr = a;
        #1;
        `CHK("mem_rdata", e, mem_rdata)
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog far beyond the 67 or so cycles of the sequence
    initial begin
        #100000;
        err_count++;
        test_done();
    end

    initial begin
        rstn = 1'b0;
        mem_wr = 1'b0;
        mem_addr = 12'h000;
        mem_wdata = 4'h0;
        data_offset = 8'h5a;
        reg_sel = 3'h0;
        pair_sel = 2'h0;
        go(4'hf, 8'h00);
        repeat (12) @(negedge ref_clk);
        rstn = 1'b1;
        @(negedge ref_clk);
        go(4'h8, 8'h00);
        fin();
        rd(12'hfb0, 4'h0);
        rd(12'hf83, 4'h0);
        rd(12'hf82, 4'h0);
        go(4'h8, 8'hc0);
        fin();
        rd(12'hfb0, 4'h3);
        go(4'ha, 8'h02);
        fin();
        `CHK("active_bank", 2'h2, rbank)
        // Register A, pair XA and the three pointers inside bank 2
        reg_sel = 3'h7;
        pair_sel = 2'h3;
        #1;
        `CHK("reg_nibble", 5'h17, rn_addr)
        `CHK("pair_xa", 5'h16, pr_addr)
        `CHK("ptr_de", 5'h12, de_addr)
        `CHK("ptr_hl", 5'h14, hl_addr)
        `CHK("ptr_dl_d", 5'h12, dld_addr)
        `CHK("ptr_dl_l", 5'h15, dll_addr)
        go(4'h9, 8'h0f);
        fin();
        go(4'h9, 8'h05);
        fin();
        `CHK("data_address", 12'hf5a, data_address)
        rd(12'hf83, 4'hf);
        // Upper bits written as ones must not stick
        for (int i = 0; i < 4; i++) begin
            mw(12'hf84, {2'h3, i[1:0]});
            `CHK("stack_bank", i[1:0], sbank)
            rd(12'hf84, {2'h0, i[1:0]});
        end
        mw(12'hf84, 4'h2);
        mw(12'hf80, 4'h0);
        mw(12'hf81, 4'h0);
        `CHK("pointer", 8'h00, sp)
        go(4'h1, 8'h00);
        #1;
        `CHK("push_addr", 10'h2ff, push_addr)
        `CHK("push_data", 8'hf2, push_data)
        fin();
        `CHK("pointer", 8'hff, sp)
        go(4'h3, 8'h00);
        #1;
        `CHK("push_data", 8'h03, push_data)
        fin();
        go(4'hb, 8'h01);
        fin();
        // Skip flags travel with the status word too
        go(4'hc, 8'h05);
        fin();
        go(4'h5, 8'h00);
        #1;
        `CHK("push_data", 8'hd3, push_data)
        fin();
        `CHK("nesting", 2'h1, nest)
        `CHK("active_bank", 2'h0, rbank)
        go(4'hb, 8'h00);
        fin();
        go(4'hc, 8'h00);
        fin();
        go(4'h6, 8'h00);
        fin();
        rd(12'hfb1, 4'hd);
        `CHK("nesting", 2'h0, nest)
        `CHK("carry", 1'b1, carry_bit)
        `CHK("active_bank", 2'h2, rbank)
        mw(12'hfb0, 4'h0);
        rd(12'hfb0, 4'h0);
        go(4'h4, 8'h00);
        fin();
        rd(12'hfb0, 4'h3);
        `CHK("carry", 1'b1, carry_bit)
        go(4'h9, 8'h00);
        fin();
        go(4'h2, 8'h00);
        fin();
        `CHK("pointer", 8'h00, sp)
        `CHK("data_address", 12'hf5a, data_address)
        // No accepts run while the nesting level is rewritten
        mw(12'hfb0, 4'hb);
        mw(12'hfb0, 4'hf);
        `CHK("nesting", 2'h2, nest)
        go(4'h5, 8'hc0);
        fin();
        `CHK("nesting", 2'h2, nest)
        mem_addr = 12'hf90;
        #1;
        `CHK("mem_hit", 1'b0, mem_hit)
        test_done();
    end
endmodule
`default_nettype wire
